// ### rtl/timer_pkg.sv
// Purpose: Shared constants for the idle and PWM/capture timer block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Idle, PWM and capture counting runs from the instruction tick, pclk divided by ten; event mode counts pin A edges.
package timer_pkg;

  // Widths of the two counters and the bit whose toggle makes the idle tick.
  localparam int TIMER_W       = 16;
  localparam int IDLE_W        = 16;
  localparam int IDLE_TICK_BIT = 12;
  // Instruction cycles between two idle ticks, derived from the tick bit.
  localparam int IDLE_TICK_INSTR_CYCLES = 1 << IDLE_TICK_BIT;

  // Clock figures: pclk period and the instruction-cycle divider.
  localparam int CLK_PERIOD_NS  = 4;
  localparam int INSTR_DIV      = 10;
  localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * INSTR_DIV;
  localparam int DIV_W          = 4;

  // Register byte offsets.
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_COUNT     = 8'h08;
  localparam logic [7:0]  OFF_RELOAD_A  = 8'h0C;
  localparam logic [7:0]  OFF_RELOAD_B  = 8'h10;
  localparam logic [7:0]  OFF_PINS      = 8'h14;

  // Control register fields.
  localparam int          CTRL_RUN_BIT     = 0;
  localparam int          CTRL_MODE_LSB    = 1;
  localparam int          CTRL_EN_A_BIT    = 4;
  localparam int          CTRL_EN_B_BIT    = 5;
  localparam int          CTRL_IDLE_EN_BIT = 6;
  localparam int          CTRL_W           = 7;
  localparam logic [6:0]  CTRL_RESET       = 7'h00;

  // Status register fields, write one to clear.
  localparam int ST_PEND_A_BIT    = 0;
  localparam int ST_PEND_B_BIT    = 1;
  localparam int ST_IDLE_PEND_BIT = 2;

  // Pin register fields, read only.
  localparam int PIN_A_BIT     = 0;
  localparam int PIN_B_BIT     = 1;
  localparam int PIN_A_OUT_BIT = 2;
  localparam int PIN_REQ_A_BIT = 3;
  localparam int PIN_REQ_B_BIT = 4;
  localparam int PIN_REQ_I_BIT = 5;

  // Mode-select codes, high bit first.
  localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
  localparam logic [2:0] MODE_PWM_QUIET  = 3'h4;
  localparam logic [2:0] MODE_EVENT_POS  = 3'h0;
  localparam logic [2:0] MODE_EVENT_NEG  = 3'h1;

  // Decoded operating mode.
  typedef enum logic [1:0] {
    MODE_PWM,
    MODE_EVENT,
    MODE_CAPTURE
  } mode_e;

endpackage

// ### rtl/idle_and_pwm_capture_timer.sv
// Purpose: Idle tick timer plus 16-bit PWM, event counter and capture timer.
// Assumes: APB3 slave, one wait state; pins are asynchronous to pclk.
// Notes:   The main timer and its two registers are not reset on purpose.
//
// Contract
// RULE1: Main timer and A/B registers power up undefined.
// RULE2: Idle timer counts down always, no software access.
// RULE3: Bit twelve toggle sets idle tick pending.
// RULE4: Idle interrupt only while its enable set.
// RULE5: Idle timer provides the shared system time base.
// RULE6: Sixteen-bit timer with reload/capture registers A, B.
// RULE7: Pin A input or output; pin B input.
// RULE8: Three mode bits select PWM, event or capture.
// RULE9: Run bit starts/stops PWM and event modes.
// RULE10: PWM counts instruction cycles, reloads on underflow.
// RULE11: First reload from A, then B, A alternately.
// RULE12: Toggle variant inverts pin A each underflow.
// RULE13: Underflows set pending A/B alternately, software clears.
// RULE14: Enable A/B gate reload-A and reload-B interrupts.
// RULE15: Event mode counts pin A edges; underflow flags A.
// RULE16: Event mode: pin B rising edge sets pending B.
// RULE17: Event mode: pin A input, no PWM output.
// RULE18: Capture mode: free run, pins copy count.
// RULE19: Capture edge polarity separate for pins A, B; code forces pin B to falling whenever pin A falls.
// RULE20: Captures set pending A/B, enables gate interrupts.
// RULE21: Capture underflow sets run bit, gated by enable A.
// RULE22: Software clears run bit, checks both flags.
// RULE23: Capture registers readable without disturbing count.
// RULE24: Pins sampled synchronously, one event per edge.
`timescale 1ns/1ns
`default_nettype none

module idle_and_pwm_capture_timer
  import timer_pkg::*;
#(
  parameter int TW = TIMER_W,
  parameter int IW = IDLE_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer_pin_a_in,
  input  wire logic              timer_pin_b_in,
  output logic                   timer_pin_a_out,
  output logic                   timer_pin_a_oe,
  output logic                   int_req_a,
  output logic                   int_req_b,
  output logic                   int_req_idle,
  output logic                   instr_tick,
  output logic      [IW-1:0]     idle_timer_value
);

  // Chooses one edge of a pin by polarity; used for both pins.
  function automatic logic pick_edge(input logic rise, input logic fall, input logic neg);
    pick_edge = neg ? fall : rise;
  endfunction

  // Flags whether an address hits one of the mapped registers.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_COUNT) ||
                  (a == OFF_RELOAD_A) || (a == OFF_RELOAD_B) || (a == OFF_PINS);
  endfunction

  // State declarations.
  logic [DIV_W-1:0]  div_reg;
  logic              tick_reg;
  logic [IW-1:0]     idle_reg;
  logic              idle_pend_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic              pend_a_reg;
  logic              pend_b_reg;
  logic              pend_a_next;
  logic              pend_b_next;
  logic              idle_pend_next;
  logic [TW-1:0]     count_reg;
  logic [TW-1:0]     count_next;
  logic [TW-1:0]     rc_a_reg;
  logic [TW-1:0]     rc_b_reg;
  logic              next_is_b_reg;
  logic              pin_a_out_reg;
  logic              a_meta_reg;
  logic              a_sync_reg;
  logic              a_last_reg;
  logic              b_meta_reg;
  logic              b_sync_reg;
  logic              b_last_reg;
  logic              ready_reg;
  logic              slverr_reg;
  logic [31:0]       rdata_reg;
  logic              req_a_reg;
  logic              req_b_reg;
  logic              req_i_reg;
  logic              oe_reg;

  // Control field decode.
  wire logic [2:0] mode_bits  = ctrl_reg[CTRL_MODE_LSB +: 3];
  wire logic       run_bit    = ctrl_reg[CTRL_RUN_BIT];
  wire logic       en_a       = ctrl_reg[CTRL_EN_A_BIT];
  wire logic       en_b       = ctrl_reg[CTRL_EN_B_BIT];
  wire logic       idle_en    = ctrl_reg[CTRL_IDLE_EN_BIT];

  // Mode decode: 10x is PWM, 00x event counting, x1x capture.
  mode_e mode;
  assign mode = (mode_bits == MODE_PWM_TOGGLE || mode_bits == MODE_PWM_QUIET) ? MODE_PWM :
                (mode_bits == MODE_EVENT_POS || mode_bits == MODE_EVENT_NEG) ? MODE_EVENT :
                MODE_CAPTURE; // [RULE8]
  wire logic is_pwm     = (mode == MODE_PWM);
  wire logic is_event   = (mode == MODE_EVENT);
  wire logic is_capture = (mode == MODE_CAPTURE);
  wire logic pwm_toggle = (mode_bits == MODE_PWM_TOGGLE);

  // Capture polarity: pin A falls when the low bit is set, pin B when either
  // the high or low bit is set; event mode uses the low bit for pin A.
  wire logic a_neg = mode_bits[0];                      // [RULE19]
  wire logic b_neg = mode_bits[2] | mode_bits[0];       // [RULE19]

  // Edges come from the second and third sample stages only, so the first
  // synchroniser flop feeds nothing but the second.
  wire logic a_rise  = a_sync_reg & ~a_last_reg;        // [RULE24]
  wire logic a_fall  = ~a_sync_reg & a_last_reg;        // [RULE24]
  wire logic b_rise  = b_sync_reg & ~b_last_reg;        // [RULE24]
  wire logic b_fall  = ~b_sync_reg & b_last_reg;        // [RULE24]
  wire logic a_event = ce & pick_edge(a_rise, a_fall, a_neg);
  wire logic b_cap   = ce & pick_edge(b_rise, b_fall, b_neg);

  // Instruction cycle strobe, qualified by the clock enable.
  wire logic tc = ce & tick_reg;

  // Idle tick: bit twelve changes when all bits below it are zero on a tick.
  wire logic idle_toggle = tc && (idle_reg[IDLE_TICK_BIT-1:0] == '0); // [RULE3]

  // Main timer decrement strobe per mode.
  wire logic dec_pwm   = is_pwm & run_bit & tc;          // [RULE9] [RULE10]
  wire logic dec_event = is_event & run_bit & a_event;   // [RULE9] [RULE15]
  wire logic dec_cap   = is_capture & tc;                // [RULE18]
  wire logic dec       = dec_pwm | dec_event | dec_cap;
  wire logic underflow = dec && (count_reg == '0);

  // PWM reload source and its pending flag.
  wire logic pwm_uf      = underflow & is_pwm;
  wire logic pwm_reload_a = pwm_uf & ~next_is_b_reg;     // [RULE11]
  wire logic pwm_reload_b = pwm_uf & next_is_b_reg;      // [RULE11]
  wire logic event_uf    = underflow & is_event;
  wire logic cap_uf      = underflow & is_capture;

  // Capture strobes.
  wire logic cap_a = is_capture & a_event;               // [RULE18]
  wire logic cap_b = is_capture & b_cap;                 // [RULE18]

  // APB access decode; a write lands on the edge where pready is seen.
  wire logic access   = ce & psel & penable;
  wire logic wr_done  = access & pwrite & ready_reg;
  wire logic wr_ctrl  = wr_done && (paddr == OFF_CTRL);
  wire logic wr_stat  = wr_done && (paddr == OFF_STATUS);
  wire logic wr_count = wr_done && (paddr == OFF_COUNT);
  wire logic wr_rc_a  = wr_done && (paddr == OFF_RELOAD_A);
  wire logic wr_rc_b  = wr_done && (paddr == OFF_RELOAD_B);
  wire logic mapped   = addr_mapped(paddr);

  // Read mux; the capture registers are plain flops so reading them never
  // touches the running count.
  logic [31:0] rd_mux;
  assign rd_mux = (paddr == OFF_CTRL)     ? {25'h0000000, ctrl_reg} :
                  (paddr == OFF_STATUS)   ? {29'h00000000, idle_pend_reg, pend_b_reg, pend_a_reg} :
                  (paddr == OFF_COUNT)    ? {16'h0000, count_reg} :
                  (paddr == OFF_RELOAD_A) ? {16'h0000, rc_a_reg} : // [RULE23]
                  (paddr == OFF_RELOAD_B) ? {16'h0000, rc_b_reg} : // [RULE23]
                  (paddr == OFF_PINS)     ? {26'h0000000, req_i_reg, req_b_reg, req_a_reg,
                                             pin_a_out_reg, b_sync_reg, a_sync_reg} :
                  32'h00000000;

  // Control next value: software writes, but a capture-mode underflow sets
  // the run bit and wins over a clearing write in the same cycle.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata[CTRL_W-1:0];
    end
    if (cap_uf) begin
      ctrl_next[CTRL_RUN_BIT] = 1'b1; // [RULE21]
    end
  end

  // Pending flags: write one to clear, hardware set takes priority.
  always_comb begin
    pend_a_next    = pend_a_reg;
    pend_b_next    = pend_b_reg;
    idle_pend_next = idle_pend_reg;
    if (wr_stat) begin
      pend_a_next    = pend_a_reg & ~pwdata[ST_PEND_A_BIT];
      pend_b_next    = pend_b_reg & ~pwdata[ST_PEND_B_BIT];
      idle_pend_next = idle_pend_reg & ~pwdata[ST_IDLE_PEND_BIT];
    end
    if (pwm_reload_a || event_uf || cap_a) begin
      pend_a_next = 1'b1; // [RULE13] [RULE15] [RULE20]
    end
    if (pwm_reload_b || (is_event && ce && b_rise) || cap_b) begin
      pend_b_next = 1'b1; // [RULE13] [RULE16] [RULE20]
    end
    if (idle_toggle) begin
      idle_pend_next = 1'b1; // [RULE3]
    end
  end

  // Main timer next value: underflow reloads in PWM and event modes and
  // wraps in capture mode; a software write to the count wins.
  always_comb begin
    count_next = count_reg;
    if (dec) begin
      count_next = count_reg - 1'b1;
    end
    if (pwm_reload_a || event_uf) begin
      count_next = rc_a_reg; // [RULE10] [RULE11]
    end
    if (pwm_reload_b) begin
      count_next = rc_b_reg; // [RULE11]
    end
    if (wr_count) begin
      count_next = pwdata[TW-1:0];
    end
  end

  // Instruction-cycle prescaler: one strobe every ten pclk cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      tick_reg <= (div_reg == DIV_W'(INSTR_DIV - 2));
      div_reg  <= (div_reg == DIV_W'(INSTR_DIV - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  // Idle timer counts down on every instruction cycle with no bus path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_reg <= '0;
    end else if (tc) begin
      idle_reg <= idle_reg - 1'b1; // [RULE2]
    end
  end

  // Pin synchronisers: two flops before any logic, a third for edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      a_last_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      b_sync_reg <= 1'b0;
      b_last_reg <= 1'b0;
    end else if (ce) begin
      a_meta_reg <= timer_pin_a_in; // [RULE24]
      a_sync_reg <= a_meta_reg;
      a_last_reg <= a_sync_reg;
      b_meta_reg <= timer_pin_b_in; // [RULE24]
      b_sync_reg <= b_meta_reg;
      b_last_reg <= b_sync_reg;
    end
  end

  // Control, flags and PWM sequencing state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= CTRL_RESET;
      pend_a_reg    <= 1'b0;
      pend_b_reg    <= 1'b0;
      idle_pend_reg <= 1'b0;
      next_is_b_reg <= 1'b0;
      pin_a_out_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg      <= ctrl_next;
      pend_a_reg    <= pend_a_next;
      pend_b_reg    <= pend_b_next;
      idle_pend_reg <= idle_pend_next;
      // Stopping or leaving PWM rearms the sequence so the next start
      // reloads from A first.
      if (!(is_pwm && run_bit)) begin
        next_is_b_reg <= 1'b0; // [RULE11]
      end else if (pwm_uf) begin
        next_is_b_reg <= ~next_is_b_reg; // [RULE11]
      end
      if (pwm_uf && pwm_toggle) begin
        pin_a_out_reg <= ~pin_a_out_reg; // [RULE12]
      end
    end
  end

  // Main timer and reload/capture registers carry no reset: their content
  // after power-up is undefined and software must load them.
  always_ff @(posedge pclk) begin
    if (ce) begin
      count_reg <= count_next; // [RULE1] [RULE6]
      if (cap_a) begin
        rc_a_reg <= count_reg; // [RULE18]
      end else if (wr_rc_a) begin
        rc_a_reg <= pwdata[TW-1:0];
      end
      if (cap_b) begin
        rc_b_reg <= count_reg; // [RULE18]
      end else if (wr_rc_b) begin
        rc_b_reg <= pwdata[TW-1:0];
      end
    end
  end

  // Interrupt requests, registered so each output comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_a_reg <= 1'b0;
      req_b_reg <= 1'b0;
      req_i_reg <= 1'b0;
    end else if (ce) begin
      req_a_reg <= en_a & (pend_a_next | (is_capture & ctrl_next[CTRL_RUN_BIT])); // [RULE14] [RULE21]
      req_b_reg <= en_b & pend_b_next;       // [RULE14] [RULE20]
      req_i_reg <= idle_en & idle_pend_next; // [RULE4]
    end
  end

  // APB slave: pready rises in the second access cycle, read data and the
  // error answer are loaded together with it; pready and pslverr last one cycle, prdata holds until the next access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg  <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else if (ce) begin
      ready_reg  <= access & ~ready_reg;
      if (access && !ready_reg) begin
        slverr_reg <= ~mapped;
        rdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
        slverr_reg <= 1'b0;
      end
    end
  end

  // Output drive: pin A is driven only in PWM mode; elsewhere it is an input.
  assign timer_pin_a_oe   = oe_reg; // [RULE7] [RULE17]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_reg <= 1'b0;
    end else if (ce) begin
      oe_reg <= is_pwm; // [RULE7] [RULE17]
    end
  end

  // Remaining outputs; the idle count and tick form the shared time base.
  assign timer_pin_a_out  = pin_a_out_reg;
  assign int_req_a        = req_a_reg;
  assign int_req_b        = req_b_reg;
  assign int_req_idle     = req_i_reg;
  assign instr_tick       = tick_reg;  // [RULE5]
  assign idle_timer_value = idle_reg;  // [RULE5]
  assign prdata           = rdata_reg;
  assign pready           = ready_reg;
  assign pslverr          = slverr_reg;

endmodule

`default_nettype wire

// ### testbench/timer_asserts.sv
// Purpose: Port-level checks for the idle and PWM/capture timer.
// Assumes: Checks pause while ce is low, since every answer stalls then.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module timer_asserts #(
  parameter int IW = 16
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          ce,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          timer_pin_a_out,
  input wire logic          timer_pin_a_oe,
  input wire logic          instr_tick,
  input wire logic [IW-1:0] idle_timer_value
);
  // Everything here lives in the pclk domain.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_ready_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("wait state count wrong");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_err_rdata; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("refused read not zero");
  // The instruction tick paces the idle, PWM and capture counts, so its spacing is checked exactly.
  property p_tick_period;
    instr_tick |=> !instr_tick [*8] ##1 !instr_tick ##1 instr_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
  property p_idle_dec;
    instr_tick |-> ##10 idle_timer_value == IW'($past(idle_timer_value, 10) - 1'b1);
  endproperty
  a_idle_dec: assert property (p_idle_dec) else $error("idle count step wrong");
  property p_pin_quiet; !timer_pin_a_oe |=> $stable(timer_pin_a_out); endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("pin A output moved");
  property p_toggle_space;
    $changed(timer_pin_a_out) |=> $stable(timer_pin_a_out) [*8];
  endproperty
  a_toggle_space: assert property (p_toggle_space) else $error("toggles too close");
endmodule
bind idle_and_pwm_capture_timer timer_asserts #(.IW(IW)) u_timer_asserts (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin_a_out(timer_pin_a_out),
  .timer_pin_a_oe(timer_pin_a_oe), .instr_tick(instr_tick),
  .idle_timer_value(idle_timer_value));
`default_nettype wire

// ### testbench/pin_source.sv
// Purpose: External event source on the two timer pins.
// Assumes: Levels change just after a rising edge and then hold.
// Notes:   HOLD sets how slowly the source moves; it must beat the synchroniser.
`timescale 1ns/1ns
`default_nettype none
module pin_source #(
  parameter int HOLD = 6
) (
  input wire logic pclk,
  input wire logic timer_pin_a_out,
  input wire logic timer_pin_a_oe,
  output wire      timer_pin_a_in,
  output logic     timer_pin_b_in
);
  logic a_drv = 1'b0;
  // Pin A is two-way: the block owns it while its enable is high.
  assign timer_pin_a_in = timer_pin_a_oe ? timer_pin_a_out : a_drv;
  initial timer_pin_b_in = 1'b0;
  // Each level is held long enough for one clean sampled edge.
  task automatic set_a(input logic v);
    @(posedge pclk) a_drv <= v;
    repeat (HOLD) @(posedge pclk);
  endtask
  // Pin B is only ever driven from outside.
  task automatic set_b(input logic v);
    @(posedge pclk) timer_pin_b_in <= v;
    repeat (HOLD) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_idle_and_pwm_capture_timer.sv
// Purpose: Self-checking bench for the idle and PWM/capture timer.
// Assumes: One clock at 250 MHz; ce dropped once to check the freeze.
// Notes:   PWM reload values come from an LFSR seeded with 2.
`timescale 1ns/1ns
`default_nettype none
module tb_idle_and_pwm_capture_timer;
  import timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, na, nb, ce;
  logic        timer_pin_a_out, timer_pin_a_oe, int_req_a, int_req_b, int_req_idle;
  logic        instr_tick, timer_pin_b_in;
  wire         timer_pin_a_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c0, cap;
  logic [15:0] seed, ra, rb, idle_timer_value;
  logic [2:0]  m;
  int          failures, compares, n;
  idle_and_pwm_capture_timer u_idle_and_pwm_capture_timer (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_pin_a_in, .timer_pin_b_in, .timer_pin_a_out, .timer_pin_a_oe, .int_req_a,
    .int_req_b, .int_req_idle, .instr_tick, .idle_timer_value);
  pin_source u_pin_source (.pclk, .timer_pin_a_out, .timer_pin_a_oe, .timer_pin_a_in,
    .timer_pin_b_in);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Control word: run bit, mode code and the two enables.
  function automatic logic [31:0] ctrl(input logic [2:0] md, input logic r, input logic [1:0] e);
    return {26'h0, e, md, r};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // The idle flag may set at any time, so status reads look at A and B only.
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, (a == OFF_STATUS) ? (rd & 32'h3) : rd, exp);
  endtask
  // Counts instruction ticks until pin A changes, with a bound.
  task automatic tog(output int t);
    logic l;
    int k;
    l = timer_pin_a_out;
    t = 0;
    for (k = 0; k < 3000 && timer_pin_a_out === l; k++) begin
      @(posedge pclk);
      #1;
      if (instr_tick === 1'b1) t++;
    end
  endtask
  task automatic close_out;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the idle tick wait dominates at about 41000 cycles.
  initial begin
    #(CLK_PERIOD_NS * 90000);
    failures++;
    close_out();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; failures = 0; compares = 0; seed = 16'h0002; ce = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl reset", OFF_CTRL, 32'h0);
    rdchk("status reset", OFF_STATUS, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Clock enable low must freeze the time base; 25 cycles span two ticks.
    @(posedge pclk) ce <= 1'b0;
    @(posedge pclk);
    #1 c0 = idle_timer_value;
    cap = instr_tick;
    repeat (25) @(posedge pclk);
    #1 chk("ce idle frozen", idle_timer_value, c0);
    chk("ce tick frozen", instr_tick, cap);
    @(posedge pclk) ce <= 1'b1;
    // PWM with toggling: reload order and spacing from the two registers.
    seed = lfsr(seed); ra = 16'h5 + seed[3:0];
    seed = lfsr(seed); rb = 16'h5 + seed[3:0];
    wr(OFF_RELOAD_A, ra); wr(OFF_RELOAD_B, rb); wr(OFF_COUNT, 32'h3); wr(OFF_STATUS, 32'h7);
    wr(OFF_CTRL, ctrl(MODE_PWM_TOGGLE, 1'b1, 2'h3));
    tog(n);
    chk("pin a oe", timer_pin_a_oe, 32'h1);
    tog(n);
    chk("gap after A", n, ra + 1);
    tog(n);
    chk("gap after B", n, rb + 1);
    repeat (3) @(posedge pclk);
    #1;
    chk("irq a", int_req_a, 32'h1);
    chk("irq b", int_req_b, 32'h1);
    rdchk("pwm flags", OFF_STATUS, 32'h3);
    wr(OFF_STATUS, 32'h3);
    rdchk("flags cleared", OFF_STATUS, 32'h0);
    // Quiet PWM without enables: flags still latch, the pin holds its level and request A stays low.
    wr(OFF_CTRL, ctrl(MODE_PWM_QUIET, 1'b1, 2'h0));
    cap = timer_pin_a_out;
    repeat (600) @(posedge pclk);
    chk("quiet pin", timer_pin_a_out, cap);
    chk("irq gated", int_req_a, 32'h0);
    rdchk("quiet flags", OFF_STATUS, 32'h3);
    // Event counting on both pin A polarities, pin B as an edge flag.
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CTRL, 32'h0); wr(OFF_RELOAD_A, 32'h9); wr(OFF_COUNT, 32'h2); wr(OFF_STATUS, 32'h7);
      wr(OFF_CTRL, ctrl(i ? MODE_EVENT_NEG : MODE_EVENT_POS, 1'b1, 2'h3));
      repeat (2) begin
        u_pin_source.set_a(1'b1);
        u_pin_source.set_a(1'b0);
      end
      rdchk("event count", OFF_COUNT, 32'h0);
      rdchk("no flag yet", OFF_STATUS, 32'h0);
      u_pin_source.set_a(1'b1);
      u_pin_source.set_a(1'b0);
      rdchk("event reload", OFF_COUNT, 32'h9);
      chk("event irq a", int_req_a, 32'h1);
      chk("pin a input", timer_pin_a_oe, 32'h0);
      u_pin_source.set_b(1'b1);
      u_pin_source.set_b(1'b0);
      rdchk("pin b flag", OFF_STATUS, 32'h3);
      chk("event irq b", int_req_b, 32'h1);
    end
    // Capture modes: wrong edges do nothing, right edges capture the count.
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 3'h2 : (i == 1) ? 3'h6 : (i == 2) ? 3'h3 : 3'h7;
      na = m[0];
      nb = m[2] | m[0];
      wr(OFF_CTRL, ctrl(m, 1'b0, 2'h0));
      u_pin_source.set_a(!na);
      u_pin_source.set_b(!nb);
      wr(OFF_COUNT, 32'hFFFF); wr(OFF_STATUS, 32'h7);
      u_pin_source.set_a(na);
      u_pin_source.set_b(nb);
      rdchk("wrong edges", OFF_STATUS, 32'h0);
      apb(1'b0, OFF_COUNT, 32'h0);
      c0 = rd;
      u_pin_source.set_a(!na);
      rdchk("cap a flag", OFF_STATUS, 32'h1);
      apb(1'b0, OFF_RELOAD_A, 32'h0);
      cap = rd;
      apb(1'b0, OFF_COUNT, 32'h0);
      chk("cap in range", cap <= c0 && cap > rd, 32'h1);
      rdchk("cap a held", OFF_RELOAD_A, cap);
      u_pin_source.set_b(!nb);
      rdchk("cap b flag", OFF_STATUS, 32'h3);
      chk("cap irq gated", int_req_b, 32'h0);
    end
    // Capture underflow raises the run bit as a flag; software clears it.
    wr(OFF_STATUS, 32'h7); wr(OFF_CTRL, ctrl(3'h2, 1'b0, 2'h1)); wr(OFF_COUNT, 32'h2);
    repeat (100) @(posedge pclk);
    rdchk("underflow flag", OFF_CTRL, ctrl(3'h2, 1'b1, 2'h1));
    chk("underflow irq", int_req_a, 32'h1);
    wr(OFF_CTRL, ctrl(3'h2, 1'b0, 2'h1));
    // Idle tick: a fresh flag after clearing, then the enable gates it.
    wr(OFF_STATUS, 32'h7);
    wr(OFF_CTRL, 32'h40);
    for (n = 0; n < 41500 && int_req_idle !== 1'b1; n++) @(posedge pclk);
    chk("idle irq", int_req_idle, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("idle flag", rd[2], 32'h1);
    wr(OFF_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk("idle masked", int_req_idle, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
